// file: core/hbc_consts.svh
// Register offsets, field positions and reset values of the break unit
`ifndef HBC_CONSTS_SVH
`define HBC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define HBC_A_CTRL   8'h00
`define HBC_A_C1ADR  8'h04
`define HBC_A_C1AMK  8'h08
`define HBC_A_C1DAT  8'h0C
`define HBC_A_C1DMK  8'h10
`define HBC_A_C1MOD  8'h14
`define HBC_A_C1CNT  8'h18
`define HBC_A_C2ADR  8'h20
`define HBC_A_C2AMK  8'h24
`define HBC_A_C2MOD  8'h28
`define HBC_A_C2CNT  8'h2C
`define HBC_A_C3CTL  8'h30
`define HBC_A_STAT   8'h34
`define HBC_A_MASK   8'h38

// ****************************************
// Channel mode word fields and channel 3 control bits
// ****************************************
`define HBC_F_FM     1:0
`define HBC_F_ABUS   3:2
`define HBC_F_DW     5:4
`define HBC_F_DBUS   7:6
`define HBC_F_AEN    8
`define HBC_F_DEN    9
`define HBC_F_ASEN   10
`define HBC_F_DIREN  11
`define HBC_F_DIRW   12
`define HBC_F_ACCEN  13
`define HBC_F_ASID   23:16
`define HBC_F_TLB    0
`define HBC_F_IO     1

// ****************************************
// Reset values and internal I/O window
// ****************************************
`define HBC_RST_W    32'h00000000
`define HBC_RST_CNT  16'h0001
`define HBC_CNT_ONE  16'h0001
`define HBC_IO_BASE  32'hFF000000
`define HBC_IO_MASK  32'hFF000000

`endif

// file: core/hbc_pkg.sv
// Types shared by the break-condition unit
package hbc_pkg;

	// Where a channel looks for its address
	typedef enum logic [1:0] {HBC_FM_ANY, HBC_FM_BEFORE,
		HBC_FM_AFTER, HBC_FM_RSV} hbc_fetch_e;

	// Which bus feeds the address or data compare
	typedef enum logic [1:0] {HBC_BUS_MAIN, HBC_BUS_X,
		HBC_BUS_Y, HBC_BUS_RSV} hbc_bus_e;

	// Access width, same coding as the core's size lines
	typedef enum logic [1:0] {HBC_DW_BYTE, HBC_DW_WORD,
		HBC_DW_LONG, HBC_DW_RSV} hbc_width_e;

endpackage

// file: core/hbc_chan.sv
// One address/data break channel: compare logic and satisfaction counter
`timescale 1ns/1ns
`include "hbc_consts.svh"

module hbc_chan
	import hbc_pkg::*;
#(
	parameter bit HAS_DATA = 1'b1
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Channel setup
	input  wire logic        en_i,
	input  wire logic [31:0] mode_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] amask_i,
	input  wire logic [31:0] data_i,
	input  wire logic [31:0] dmask_i,
	input  wire logic [15:0] tgt_i,
	// Observed core activity
	input  wire logic        cyc_valid_i,
	input  wire logic [31:0] cyc_addr_i,
	input  wire logic [31:0] cyc_data_i,
	input  wire logic [1:0]  cyc_size_i,
	input  wire logic        cyc_fetch_i,
	input  wire logic        cyc_write_i,
	input  wire logic        cyc_exec_i,
	input  wire logic        x_valid_i,
	input  wire logic [31:0] x_addr_i,
	input  wire logic [31:0] x_data_i,
	input  wire logic        y_valid_i,
	input  wire logic [31:0] y_addr_i,
	input  wire logic [31:0] y_data_i,
	input  wire logic        ret_i,
	input  wire logic [31:0] ret_addr_i,
	input  wire logic [7:0]  asid_i,
	// Result
	output logic             fire_o,
	output logic [15:0]      cnt_o
);

	// Masked equality, a set mask bit drops that bit from the compare
	function automatic logic meq(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] m);
		meq = ((a ^ b) & ~m) == `HBC_RST_W;
	endfunction

	// Mode fields
	hbc_fetch_e fm;
	hbc_bus_e   abus;
	hbc_bus_e   dbus;
	assign fm   = hbc_fetch_e'(mode_i[`HBC_F_FM]);
	assign abus = hbc_bus_e'(mode_i[`HBC_F_ABUS]);
	assign dbus = hbc_bus_e'(mode_i[`HBC_F_DBUS]);

	// Address source and compare
	wire        a_vld  = (abus == HBC_BUS_X) ? x_valid_i :
		(abus == HBC_BUS_Y) ? y_valid_i : cyc_valid_i;
	wire [31:0] a_val  = (abus == HBC_BUS_X) ? x_addr_i :
		(abus == HBC_BUS_Y) ? y_addr_i : cyc_addr_i;
	wire        a_hit  = a_vld && meq(a_val, addr_i, amask_i);
	// Before-execution fetch: exact address on a fetch cycle, mask unused
	wire        b_hit  = cyc_valid_i && cyc_fetch_i &&
		(cyc_addr_i == addr_i);
	// After-execution: the instruction at the address has retired
	wire        r_hit  = ret_i && meq(ret_addr_i, addr_i, amask_i);
	wire        as_ok  = !mode_i[`HBC_F_ASEN] ||
		(asid_i == mode_i[`HBC_F_ASID]);

	// Data compare, on the selected width or on the X/Y data bus
	wire        dw_ok  = cyc_valid_i && (cyc_size_i == mode_i[`HBC_F_DW]);
	wire        d_hit  = (dbus == HBC_BUS_X) ?
		(x_valid_i && meq(x_data_i, data_i, dmask_i)) :
		(dbus == HBC_BUS_Y) ? (y_valid_i && meq(y_data_i, data_i, dmask_i)) :
		(dw_ok && meq(cyc_data_i, data_i, dmask_i));
	wire        d_ok   = !(HAS_DATA && mode_i[`HBC_F_DEN]) || d_hit;
	wire        dir_ok = !mode_i[`HBC_F_DIREN] ||
		(cyc_write_i == mode_i[`HBC_F_DIRW]);
	wire        acc_ok = !mode_i[`HBC_F_ACCEN] || cyc_exec_i;

	// All terms are ANDed; without an address term any bus cycle qualifies
	wire        any_ok = (mode_i[`HBC_F_AEN] ? a_hit : cyc_valid_i) &&
		d_ok && dir_ok && acc_ok && as_ok;
	wire        cond   = en_i && ((fm == HBC_FM_BEFORE) ? (b_hit && as_ok) :
		(fm == HBC_FM_AFTER) ? (r_hit && as_ok) : any_ok);

	// Satisfaction counter, a target of zero acts as one
	wire [15:0] tgt_e  = (tgt_i == 16'h0000) ? `HBC_CNT_ONE : tgt_i;
	wire [15:0] cnt_p1 = cnt_o + `HBC_CNT_ONE;
	assign fire_o = cond && (cnt_p1 == tgt_e);
	wire [15:0] next_cnt = !en_i ? 16'h0000 :
		(cond ? (fire_o ? 16'h0000 : cnt_p1) : cnt_o);

	// Counter state, cleared while the channel is off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= 16'h0000;
		end else begin
			cnt_o <= next_cnt;
		end
	end

	// Checks on the compare and the counter
	count_reach_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fire_o |-> (cnt_o + `HBC_CNT_ONE) == tgt_e && cond)
		else $error("break fired before count reached");
	before_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fire_o && fm == HBC_FM_BEFORE |-> cyc_fetch_i && cyc_addr_i == addr_i)
		else $error("before-fetch break without fetch match");

endmodule

// file: core/hbc_top.sv
// Three-channel hardware break-condition unit with Wishbone registers
`timescale 1ns/1ns
`include "hbc_consts.svh"

module hbc_top
	import hbc_pkg::*;
#(
	parameter logic [31:0] IO_BASE = `HBC_IO_BASE,
	parameter logic [31:0] IO_MASK = `HBC_IO_MASK
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Main bus cycle of the core
	input  wire logic        cyc_valid_i,
	input  wire logic [31:0] cyc_addr_i,
	input  wire logic [31:0] cyc_data_i,
	input  wire logic [1:0]  cyc_size_i,
	input  wire logic        cyc_fetch_i,
	input  wire logic        cyc_write_i,
	input  wire logic        cyc_exec_i,
	// X and Y memory buses
	input  wire logic        x_valid_i,
	input  wire logic [31:0] x_addr_i,
	input  wire logic [31:0] x_data_i,
	input  wire logic        y_valid_i,
	input  wire logic [31:0] y_addr_i,
	input  wire logic [31:0] y_data_i,
	// Pipeline events
	input  wire logic        ret_i,
	input  wire logic [31:0] ret_addr_i,
	input  wire logic        ldtlb_exec_i,
	input  wire logic [7:0]  asid_i,
	// Break request and interrupt
	output logic             brk_req_o,
	output logic [2:0]       brk_chan_o,
	output logic             irq_o
);

	// ****************************************
	// Helpers
	// ****************************************

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			lane[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	logic [31:0] ctrl;
	logic [31:0] c1_adr;
	logic [31:0] c1_amk;
	logic [31:0] c1_dat;
	logic [31:0] c1_dmk;
	logic [31:0] c1_mod;
	logic [31:0] c1_cnt;
	logic [31:0] c2_adr;
	logic [31:0] c2_amk;
	logic [31:0] c2_mod;
	logic [31:0] c2_cnt;
	logic [31:0] c3_ctl;
	logic [31:0] status;
	logic [31:0] mask;

	// ****************************************
	// Bus decode
	// ****************************************

	// A write lands on the edge where the master sees ack
	wire       req   = wb_cyc_i && wb_stb_i;
	wire       wr    = req && wb_we_i && wb_ack_o;
	wire [7:0] ofs   = wb_adr_i[7:0];
	wire       s_ctl = ofs == `HBC_A_CTRL;
	wire       s_1a  = ofs == `HBC_A_C1ADR;
	wire       s_1am = ofs == `HBC_A_C1AMK;
	wire       s_1d  = ofs == `HBC_A_C1DAT;
	wire       s_1dm = ofs == `HBC_A_C1DMK;
	wire       s_1m  = ofs == `HBC_A_C1MOD;
	wire       s_1c  = ofs == `HBC_A_C1CNT;
	wire       s_2a  = ofs == `HBC_A_C2ADR;
	wire       s_2am = ofs == `HBC_A_C2AMK;
	wire       s_2m  = ofs == `HBC_A_C2MOD;
	wire       s_2c  = ofs == `HBC_A_C2CNT;
	wire       s_3   = ofs == `HBC_A_C3CTL;
	wire       s_st  = ofs == `HBC_A_STAT;
	wire       s_mk  = ofs == `HBC_A_MASK;

	// Counter readback: live count high, target low
	wire [15:0] c1_now;
	wire [15:0] c2_now;

	// Read mux; unmapped offsets answer zero
	wire [31:0] rd_mux =
		s_ctl ? {29'h0, ctrl[2:0]} :
		s_1a  ? c1_adr :
		s_1am ? c1_amk :
		s_1d  ? c1_dat :
		s_1dm ? c1_dmk :
		s_1m  ? c1_mod :
		s_1c  ? {c1_now, c1_cnt[15:0]} :
		s_2a  ? c2_adr :
		s_2am ? c2_amk :
		s_2m  ? c2_mod :
		s_2c  ? {c2_now, c2_cnt[15:0]} :
		s_3   ? {30'h0, c3_ctl[1:0]} :
		s_st  ? {29'h0, status[2:0]} :
		s_mk  ? {29'h0, mask[2:0]} : 32'h00000000;

	// Ack one cycle after the request, dropped right after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `HBC_RST_W;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************

	// Plain read/write storage with byte lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl   <= `HBC_RST_W;
			c1_adr <= `HBC_RST_W;
			c1_amk <= `HBC_RST_W;
			c1_dat <= `HBC_RST_W;
			c1_dmk <= `HBC_RST_W;
			c1_mod <= `HBC_RST_W;
			c1_cnt <= {16'h0000, `HBC_RST_CNT};
			c2_adr <= `HBC_RST_W;
			c2_amk <= `HBC_RST_W;
			c2_mod <= `HBC_RST_W;
			c2_cnt <= {16'h0000, `HBC_RST_CNT};
			c3_ctl <= `HBC_RST_W;
			mask   <= `HBC_RST_W;
		end else if (wr) begin
			if (s_ctl) ctrl <= lane(ctrl, wb_dat_i, wb_sel_i);
			if (s_1a)  c1_adr <= lane(c1_adr, wb_dat_i, wb_sel_i);
			if (s_1am) c1_amk <= lane(c1_amk, wb_dat_i, wb_sel_i);
			if (s_1d)  c1_dat <= lane(c1_dat, wb_dat_i, wb_sel_i);
			if (s_1dm) c1_dmk <= lane(c1_dmk, wb_dat_i, wb_sel_i);
			if (s_1m)  c1_mod <= lane(c1_mod, wb_dat_i, wb_sel_i);
			if (s_1c)  c1_cnt <= lane(c1_cnt, wb_dat_i, wb_sel_i);
			if (s_2a)  c2_adr <= lane(c2_adr, wb_dat_i, wb_sel_i);
			if (s_2am) c2_amk <= lane(c2_amk, wb_dat_i, wb_sel_i);
			if (s_2m)  c2_mod <= lane(c2_mod, wb_dat_i, wb_sel_i);
			if (s_2c)  c2_cnt <= lane(c2_cnt, wb_dat_i, wb_sel_i);
			if (s_3)   c3_ctl <= lane(c3_ctl, wb_dat_i, wb_sel_i);
			if (s_mk)  mask <= lane(mask, wb_dat_i, wb_sel_i);
		end
	end

	// ****************************************
	// Break channels
	// ****************************************
	wire [2:0] fire;

	// Channel 1: full condition set including data
	hbc_chan #(
		.HAS_DATA (1'b1)
	) u_ch1 (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.en_i        (ctrl[0]),
		.mode_i      (c1_mod),
		.addr_i      (c1_adr),
		.amask_i     (c1_amk),
		.data_i      (c1_dat),
		.dmask_i     (c1_dmk),
		.tgt_i       (c1_cnt[15:0]),
		.cyc_valid_i (cyc_valid_i),
		.cyc_addr_i  (cyc_addr_i),
		.cyc_data_i  (cyc_data_i),
		.cyc_size_i  (cyc_size_i),
		.cyc_fetch_i (cyc_fetch_i),
		.cyc_write_i (cyc_write_i),
		.cyc_exec_i  (cyc_exec_i),
		.x_valid_i   (x_valid_i),
		.x_addr_i    (x_addr_i),
		.x_data_i    (x_data_i),
		.y_valid_i   (y_valid_i),
		.y_addr_i    (y_addr_i),
		.y_data_i    (y_data_i),
		.ret_i       (ret_i),
		.ret_addr_i  (ret_addr_i),
		.asid_i      (asid_i),
		.fire_o      (fire[0]),
		.cnt_o       (c1_now)
	);

	// Channel 2: same set with the data term cut out
	hbc_chan #(
		.HAS_DATA (1'b0)
	) u_ch2 (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.en_i        (ctrl[1]),
		.mode_i      (c2_mod),
		.addr_i      (c2_adr),
		.amask_i     (c2_amk),
		.data_i      (`HBC_RST_W),
		.dmask_i     (`HBC_RST_W),
		.tgt_i       (c2_cnt[15:0]),
		.cyc_valid_i (cyc_valid_i),
		.cyc_addr_i  (cyc_addr_i),
		.cyc_data_i  (cyc_data_i),
		.cyc_size_i  (cyc_size_i),
		.cyc_fetch_i (cyc_fetch_i),
		.cyc_write_i (cyc_write_i),
		.cyc_exec_i  (cyc_exec_i),
		.x_valid_i   (x_valid_i),
		.x_addr_i    (x_addr_i),
		.x_data_i    (x_data_i),
		.y_valid_i   (y_valid_i),
		.y_addr_i    (y_addr_i),
		.y_data_i    (y_data_i),
		.ret_i       (ret_i),
		.ret_addr_i  (ret_addr_i),
		.asid_i      (asid_i),
		.fire_o      (fire[1]),
		.cnt_o       (c2_now)
	);

	// Channel 3: TLB-load and internal I/O only, no counter
	wire io_hit = cyc_valid_i && ((cyc_addr_i & IO_MASK) == IO_BASE);
	wire tlb_ev = c3_ctl[`HBC_F_TLB] && ldtlb_exec_i;
	wire io_ev  = c3_ctl[`HBC_F_IO] && io_hit;
	assign fire[2] = ctrl[2] && (tlb_ev || io_ev);

	// ****************************************
	// Break request, status and interrupt
	// ****************************************

	// Write-one clears; a new hit in the same cycle wins
	wire [2:0] st_clr = (wr && s_st) ?
		(wb_dat_i[2:0] & {3{wb_sel_i[0]}}) : 3'h0;
	wire [2:0] next_status = (status[2:0] & ~st_clr) | fire;
	// Level uses the mask as it stands after this edge, so no stale cycle
	wire [31:0] next_mask = (wr && s_mk) ?
		lane(mask, wb_dat_i, wb_sel_i) : mask;
	wire       next_irq = |(next_status & next_mask[2:0]);

	// Break goes out the cycle after the match, high for as many cycles as the match lasts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brk_req_o  <= 1'b0;
			brk_chan_o <= 3'h0;
			status     <= `HBC_RST_W;
			irq_o      <= 1'b0;
		end else begin
			brk_req_o  <= |fire;
			brk_chan_o <= fire;
			status     <= {29'h0, next_status};
			irq_o      <= next_irq;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	brk_next_a: assert property (
		fire[0] |=> brk_req_o && brk_chan_o[0])
		else $error("channel 1 match not followed by break");
	brk_cause_a: assert property (
		brk_req_o |-> $past(|fire) && brk_chan_o != 3'h0)
		else $error("break request without a match");
	ch_off_a: assert property (
		!ctrl[1] |=> !brk_chan_o[1])
		else $error("disabled channel 2 raised a break");
	tlb_brk_a: assert property (
		ctrl[2] && c3_ctl[`HBC_F_TLB] && ldtlb_exec_i |=> brk_chan_o[2])
		else $error("TLB-load execution missed");
	io_brk_a: assert property (
		ctrl[2] && c3_ctl[`HBC_F_IO] && io_hit |=> brk_chan_o[2])
		else $error("internal I/O access missed");
	ch3_src_a: assert property (
		brk_chan_o[2] |-> $past(ldtlb_exec_i || io_hit))
		else $error("channel 3 broke on a foreign condition");
	sticky_set_a: assert property (
		fire[1] |=> status[1] [*2] or ##1 (status[1] ##1 1'b1))
		else $error("status bit not set by a hit");
	irq_level_a: assert property (
		irq_o == |(status[2:0] & mask[2:0]))
		else $error("interrupt does not follow masked status");
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");

	// Main scenarios
	ch1_cov: cover property (brk_chan_o[0]);
	ch2_cov: cover property (brk_chan_o[1]);
	ch3_cov: cover property (brk_chan_o[2]);
	irq_cov: cover property (irq_o ##1 !irq_o);

endmodule

// file: test/hbc_core_model.sv
// Behavioural model of the core bus and pipeline seen by the break unit
`timescale 1ns/1ns

module hbc_core_model (
	// Clock
	input  wire logic        clk_i,
	// Main bus cycle
	output logic             cyc_valid_o,
	output logic [31:0]      cyc_addr_o,
	output logic [31:0]      cyc_data_o,
	output logic [1:0]       cyc_size_o,
	output logic             cyc_fetch_o,
	output logic             cyc_write_o,
	output logic             cyc_exec_o,
	// X and Y buses
	output logic             x_valid_o,
	output logic [31:0]      x_addr_o,
	output logic [31:0]      x_data_o,
	output logic             y_valid_o,
	output logic [31:0]      y_addr_o,
	output logic [31:0]      y_data_o,
	// Pipeline events
	output logic             ret_o,
	output logic [31:0]      ret_addr_o,
	output logic             ldtlb_o,
	output logic [7:0]       asid_o
);
	// ****************************************
	// Stimulus
	// ****************************************
	// Quiet core at time zero
	initial begin
		{x_valid_o, y_valid_o} = 2'b00;
		{x_addr_o, x_data_o, y_addr_o, y_data_o} = {4{32'h00000000}};
		{cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_exec_o} = 4'h0;
		{cyc_addr_o, cyc_data_o, ret_addr_o} = {3{32'h00000000}};
		{cyc_size_o, ret_o, ldtlb_o, asid_o} = 12'h000;
	end

	// One bus cycle; address and data flip afterwards as a released bus
	task automatic bus(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] sz, input logic f, input logic w, input logic e);
		@(posedge clk_i);
		{cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_exec_o} <= {1'b1, f, w, e};
		{cyc_addr_o, cyc_data_o, cyc_size_o} <= {a, d, sz};
		@(posedge clk_i);
		{cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_exec_o} <= 4'h0;
		{cyc_addr_o, cyc_data_o} <= {~a, ~d};
	endtask

	// One X (s low) or Y (s high) memory cycle; released lines show inverse
	task automatic xy(input logic s, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		{x_valid_o, y_valid_o} <= {!s, s};
		{x_addr_o, x_data_o, y_addr_o, y_data_o} <= {a, d, a, d};
		@(posedge clk_i);
		{x_valid_o, y_valid_o} <= 2'b00;
		{x_addr_o, x_data_o, y_addr_o, y_data_o} <= {~a, ~d, ~a, ~d};
	endtask

	// Instruction at a finishes execution
	task automatic retire(input logic [31:0] a);
		@(posedge clk_i);
		{ret_o, ret_addr_o} <= {1'b1, a};
		@(posedge clk_i);
		{ret_o, ret_addr_o} <= {1'b0, ~a};
	endtask

	// TLB-load instruction executes
	task automatic tlb();
		@(posedge clk_i);
		ldtlb_o <= 1'b1;
		@(posedge clk_i);
		ldtlb_o <= 1'b0;
	endtask

	// New current address space identifier
	task automatic set_asid(input logic [7:0] v);
		@(posedge clk_i);
		asid_o <= v;
	endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the three-channel break-condition unit
`timescale 1ns/1ns
`include "hbc_consts.svh"

module testbench
	import hbc_pkg::*;
;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam logic [31:0] M_AEN   = 32'h1 << `HBC_F_AEN;
	localparam logic [31:0] M_DEN   = 32'h1 << `HBC_F_DEN;
	localparam logic [31:0] M_ASEN  = 32'h1 << `HBC_F_ASEN;
	localparam logic [31:0] M_DIREN = 32'h1 << `HBC_F_DIREN;
	localparam logic [31:0] M_DIRW  = 32'h1 << `HBC_F_DIRW;
	localparam logic [31:0] M_ACCEN = 32'h1 << `HBC_F_ACCEN;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, brk_req, irq;
	logic [31:0] wb_adr, wb_dat, wb_rd, c_addr, c_data, x_a, x_d, y_a, y_d;
	logic [31:0] r_addr;
	logic [2:0]  brk_chan;
	logic [1:0]  c_size;
	logic        c_valid, c_fetch, c_write, c_exec, x_v, y_v, ret, ldtlb;
	logic [7:0]  asid;
	int          n_mismatch, compares;

	hbc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
		.wb_ack_o(wb_ack), .cyc_valid_i(c_valid), .cyc_addr_i(c_addr),
		.cyc_data_i(c_data), .cyc_size_i(c_size), .cyc_fetch_i(c_fetch),
		.cyc_write_i(c_write), .cyc_exec_i(c_exec), .x_valid_i(x_v),
		.x_addr_i(x_a), .x_data_i(x_d), .y_valid_i(y_v), .y_addr_i(y_a),
		.y_data_i(y_d), .ret_i(ret), .ret_addr_i(r_addr),
		.ldtlb_exec_i(ldtlb), .asid_i(asid), .brk_req_o(brk_req),
		.brk_chan_o(brk_chan), .irq_o(irq));

	hbc_core_model core (.clk_i(clk_i), .cyc_valid_o(c_valid),
		.cyc_addr_o(c_addr), .cyc_data_o(c_data), .cyc_size_o(c_size),
		.cyc_fetch_o(c_fetch), .cyc_write_o(c_write), .cyc_exec_o(c_exec),
		.x_valid_o(x_v), .x_addr_o(x_a), .x_data_o(x_d), .y_valid_o(y_v),
		.y_addr_o(y_a), .y_data_o(y_d), .ret_o(ret), .ret_addr_o(r_addr),
		.ldtlb_o(ldtlb), .asid_o(asid));

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic end_of_test();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Break pulse and channel bits are judged together
	task automatic cmp_brk(input logic er, input logic [2:0] ec);
		cmp32({28'h0, brk_req, brk_chan}, {28'h0, er, ec});
	endtask

	// Classic cycle: hold everything until ack is sampled, bounded wait
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we} <= {2'b11, we};
		{wb_adr, wb_dat} <= {24'h000000, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_rd;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
		if (n >= 20) begin
			n_mismatch++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h00000000, q);
		cmp32(q, exp);
	endtask

	// Let the edge settle before looking at the level output
	task automatic irq_chk(input logic exp);
		#1;
		cmp32({31'h0, irq}, {31'h0, exp});
	endtask

	// One core cycle, then the registered answer one edge later
	task automatic hit(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] sz, input logic [2:0] fwe, input logic er,
		input logic [2:0] ec);
		core.bus(a, d, sz, fwe[2], fwe[1], fwe[0]);
		#1;
		cmp_brk(er, ec);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_regs();
		rd_chk(`HBC_A_CTRL, 32'h00000000);
		rd_chk(`HBC_A_C1CNT, 32'h00000001);
		rd_chk(`HBC_A_C2CNT, 32'h00000001);
		wr(8'h3C, 32'hFFFFFFFF);
		rd_chk(8'h3C, 32'h00000000);
	endtask

	// Masked low nibble; reads, fetches and writes all compared
	task automatic s_addr();
		wr(`HBC_A_C1ADR, 32'h00001000);
		wr(`HBC_A_C1AMK, 32'h0000000F);
		wr(`HBC_A_C1MOD, M_AEN);
		wr(`HBC_A_CTRL, 32'h00000001);
		hit(32'h00001005, 32'h0, 2'h2, 3'b000, 1'b1, 3'h1);
		hit(32'h00001010, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
		hit(32'h0000100A, 32'h0, 2'h2, 3'b100, 1'b1, 3'h1);
		hit(32'h0000100F, 32'h0, 2'h2, 3'b010, 1'b1, 3'h1);
		wr(`HBC_A_CTRL, 32'h00000000);
		hit(32'h00001005, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
	endtask

	// Break only on the third satisfaction, counter restarts
	task automatic s_count();
		wr(`HBC_A_C1CNT, 32'h00000003);
		wr(`HBC_A_CTRL, 32'h00000001);
		for (int i = 1; i <= 3; i++) begin
			hit(32'h00001001, 32'h0, 2'h2, 3'b000, i == 3, 3'(i / 3));
		end
		rd_chk(`HBC_A_C1CNT, 32'h00000003);
		wr(`HBC_A_C1CNT, 32'h00000001);
	endtask

	// Data term alone, longword width, low byte masked
	task automatic s_data();
		wr(`HBC_A_C1DAT, 32'h12345678);
		wr(`HBC_A_C1DMK, 32'h000000FF);
		wr(`HBC_A_C1MOD, M_DEN | (32'(HBC_DW_LONG) << 4));
		hit(32'h00000000, 32'h123456AA, 2'h2, 3'b000, 1'b1, 3'h1);
		hit(32'h00000000, 32'h123456AA, 2'h0, 3'b000, 1'b0, 3'h0);
		hit(32'h00000000, 32'h02345678, 2'h2, 3'b000, 1'b0, 3'h0);
	endtask

	// Channel 2: writes only, top ASID value
	task automatic s_dir_asid();
		wr(`HBC_A_C2ADR, 32'h00002000);
		wr(`HBC_A_C2MOD, M_AEN | M_ASEN | M_DIREN | M_DIRW | 32'h00FF0000);
		wr(`HBC_A_CTRL, 32'h00000002);
		core.set_asid(8'hFF);
		hit(32'h00002000, 32'h0, 2'h2, 3'b010, 1'b1, 3'h2);
		hit(32'h00002000, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
		core.set_asid(8'h10);
		hit(32'h00002000, 32'h0, 2'h2, 3'b010, 1'b0, 3'h0);
	endtask

	// Before-fetch ignores the mask; after-fetch waits for retirement
	task automatic s_fetch();
		wr(`HBC_A_C2AMK, 32'h0000000F);
		wr(`HBC_A_C2MOD, M_AEN | 32'h00000001);
		hit(32'h00002000, 32'h0, 2'h2, 3'b100, 1'b1, 3'h2);
		hit(32'h00002004, 32'h0, 2'h2, 3'b100, 1'b0, 3'h0);
		wr(`HBC_A_C2AMK, 32'h00000000);
		wr(`HBC_A_C2MOD, M_AEN | 32'h00000002);
		hit(32'h00002000, 32'h0, 2'h2, 3'b100, 1'b0, 3'h0);
		core.retire(32'h00002000);
		#1;
		cmp_brk(1'b1, 3'h2);
		wr(`HBC_A_C2MOD, M_AEN | M_ACCEN);
		hit(32'h00002000, 32'h0, 2'h2, 3'b001, 1'b1, 3'h2);
		hit(32'h00002000, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
	endtask

	// Channel 3 events
	task automatic s_ch3();
		wr(`HBC_A_C3CTL, 32'h00000003);
		wr(`HBC_A_CTRL, 32'h00000004);
		core.tlb();
		#1;
		cmp_brk(1'b1, 3'h4);
		hit(32'hFF000010, 32'h0, 2'h2, 3'b000, 1'b1, 3'h4);
		hit(32'h00000010, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
		wr(`HBC_A_C3CTL, 32'h00000001);
		hit(32'hFF000010, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
	endtask

	// Channel 1 address term moved to the X bus; Y and main bus ignored
	task automatic s_xy();
		wr(`HBC_A_C1MOD, M_AEN | (32'(HBC_BUS_X) << 2));
		wr(`HBC_A_CTRL, 32'h00000001);
		core.xy(1'b0, 32'h00001003, 32'h0);
		#1;
		cmp_brk(1'b1, 3'h1);
		core.xy(1'b1, 32'h00001003, 32'h0);
		#1;
		cmp_brk(1'b0, 3'h0);
		hit(32'h00001003, 32'h0, 2'h2, 3'b000, 1'b0, 3'h0);
	endtask

	// Sticky status, mask gating, write-one clear
	task automatic s_irq();
		wr(`HBC_A_STAT, 32'h00000007);
		wr(`HBC_A_MASK, 32'h00000000);
		wr(`HBC_A_C1MOD, M_AEN);
		wr(`HBC_A_CTRL, 32'h00000001);
		hit(32'h00001005, 32'h0, 2'h2, 3'b000, 1'b1, 3'h1);
		rd_chk(`HBC_A_STAT, 32'h00000001);
		irq_chk(1'b0);
		wr(`HBC_A_MASK, 32'h00000001);
		rd_chk(`HBC_A_MASK, 32'h00000001);
		irq_chk(1'b1);
		wr(`HBC_A_STAT, 32'h00000001);
		rd_chk(`HBC_A_STAT, 32'h00000000);
		irq_chk(1'b0);
	endtask

	// ****************************************
	// Clock and main sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		{rst_i, wb_cyc, wb_stb, wb_we} = 4'b1000;
		{wb_adr, wb_dat} = 64'h0;
		{n_mismatch, compares} = {32'd0, 32'd0};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		s_regs();
		s_addr();
		s_count();
		s_data();
		s_dir_asid();
		s_fetch();
		s_ch3();
		s_xy();
		s_irq();
		end_of_test();
	end
endmodule
